//--- rtl/rhda_regs.vh
// Register map, field positions, reset values and timing of the root hub descriptor block
`ifndef RHDA_REGS_VH
`define RHDA_REGS_VH

// Byte offsets within the block
`define RHDA_ADDR_W          8
`define RHDA_DESC_A_ADDR     8'h48
`define RHDA_MASK_ADDR       8'h80
`define RHDA_PWR_ADDR        8'h84

// Descriptor field positions
`define RHDA_PGD_MSB         31
`define RHDA_PGD_LSB         24
`define RHDA_NO_OVERCURRENT_GUARD_BIT        12
`define RHDA_OVERCURRENT_REPORT_MODE_BIT        11
`define RHDA_DT_BIT          10
`define RHDA_NPS_BIT         9
`define RHDA_PSM_BIT         8
`define RHDA_NDP_MSB         7
`define RHDA_NDP_LSB         0

// Descriptor reset values
`define RHDA_PGD_RST         8'hFF
`define RHDA_NO_OVERCURRENT_GUARD_RST        1'b0
`define RHDA_NPS_RST         1'b0
`define RHDA_PSM_RST         1'b1
`define RHDA_DT_VAL          1'b0

// Power command and status layout (port p sits at bit p, bit 0 unused for ports)
`define RHDA_GLB_ON_BIT      0
`define RHDA_GLB_OFF_BIT     16
`define RHDA_PORT_ON_LSB     0
`define RHDA_PORT_OFF_LSB    16
`define RHDA_GOOD_LSB        16

// Timing: one power-good delay unit, and the clock period
`define RHDA_PGD_UNIT_NS     2000000
`define RHDA_CLK_PERIOD_NS   10

`endif

//--- rtl/rhda_port.v
// One downstream port: power switch state and power-good timer
`timescale 1ns/1ps

module rhda_port (
  hclk,
  hresetn,
  always_powered,
  power_switch_style,
  port_power_mask,
  glb_on,
  glb_off,
  port_on,
  port_off,
  tick,
  power_good_delay,
  port_power,
  port_good
);
  input  wire       hclk;
  input  wire       hresetn;
  input  wire       always_powered;
  input  wire       power_switch_style;
  input  wire       port_power_mask;
  input  wire       glb_on;
  input  wire       glb_off;
  input  wire       port_on;
  input  wire       port_off;
  input  wire       tick;
  input  wire [7:0] power_good_delay;
  output wire       port_power;
  output wire       port_good;

  reg        power_q;
  reg        power_d;
  reg  [8:0] wait_q;
  reg  [8:0] wait_d;
  reg        power_prev_q;
  wire       use_port_cmd;

  // Individual style with the mask set listens to port commands only
  assign use_port_cmd = power_switch_style & port_power_mask;

  // Switch state; an on command beats an off command in the same cycle
  always @* begin
    power_d = power_q;
    if (use_port_cmd) begin
      if (port_on)
        power_d = 1'b1;
      else if (port_off)
        power_d = 1'b0;
    end else begin
      if (glb_on)
        power_d = 1'b1;
      else if (glb_off)
        power_d = 1'b0;
    end
  end

  assign port_power = always_powered | power_q;

  // Timer loads delay plus one so a partial first unit never shortens the wait
  always @* begin
    wait_d = wait_q;
    if (port_power && !power_prev_q)
      wait_d = {1'b0, power_good_delay} + 9'h001;
    else if (!port_power)
      wait_d = 9'h000;
    else if (tick && wait_q != 9'h000)
      wait_d = wait_q - 9'h001;
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      power_q      <= 1'b0;
      power_prev_q <= 1'b0;
      wait_q       <= 9'h000;
    end else begin
      power_q      <= power_d;
      power_prev_q <= port_power;
      wait_q       <= wait_d;
    end
  end

  assign port_good = port_power & power_prev_q & (wait_q == 9'h000);

endmodule // rhda_port

//--- rtl/rhda_top.v
// Root hub descriptor register with AHB-Lite slave, port power and overcurrent report
`timescale 1ns/1ps
`include "rhda_regs.vh"

module rhda_top #(
  parameter NUM_PORTS   = 2,
  parameter TICK_CYCLES = `RHDA_PGD_UNIT_NS / `RHDA_CLK_PERIOD_NS
) (
  hclk,
  hresetn,
  hsel,
  haddr,
  htrans,
  hwrite,
  hsize,
  hwdata,
  hready,
  hrdata,
  hreadyout,
  hresp,
  port_overcurrent,
  power_good_delay,
  no_overcurrent_guard,
  overcurrent_report_mode,
  compound_flag,
  always_powered,
  power_switch_style,
  downstream_port_count,
  port_power_mask,
  port_power,
  port_good,
  overcurrent_global,
  overcurrent_port
);
  input  wire                 hclk;
  input  wire                 hresetn;
  input  wire                 hsel;
  input  wire [31:0]          haddr;
  input  wire [1:0]           htrans;
  input  wire                 hwrite;
  input  wire [2:0]           hsize;
  input  wire [31:0]          hwdata;
  input  wire                 hready;
  output wire [31:0]          hrdata;
  output wire                 hreadyout;
  output wire                 hresp;
  input  wire [NUM_PORTS-1:0] port_overcurrent;
  output wire [7:0]           power_good_delay;
  output wire                 no_overcurrent_guard;
  output wire                 overcurrent_report_mode;
  output wire                 compound_flag;
  output wire                 always_powered;
  output wire                 power_switch_style;
  output wire [7:0]           downstream_port_count;
  output wire [NUM_PORTS-1:0] port_power_mask;
  output wire [NUM_PORTS-1:0] port_power;
  output wire [NUM_PORTS-1:0] port_good;
  output wire                 overcurrent_global;
  output wire [NUM_PORTS-1:0] overcurrent_port;

  // Port count is fixed by the build, not by software
  localparam [7:0] NDP_VAL = NUM_PORTS;

  // Bus capture
  reg                     wr_q;
  reg [`RHDA_ADDR_W-1:0]  addr_q;
  reg [31:0]              rdata_q;
  reg [31:0]              rdata_d;
  wire                    take;

  // Descriptor fields
  reg [7:0]               pgd_q;
  reg [7:0]               pgd_d;
  reg                     no_overcurrent_guard_q;
  reg                     no_overcurrent_guard_d;
  reg                     overcurrent_report_mode_q;
  reg                     overcurrent_report_mode_d;
  reg                     nps_q;
  reg                     nps_d;
  reg                     psm_q;
  reg                     psm_d;

  // Own control and command decode
  reg [NUM_PORTS-1:0]     mask_q;
  reg [NUM_PORTS-1:0]     mask_d;
  wire                    wr_desc;
  wire                    wr_mask;
  wire                    wr_pwr;
  wire                    glb_on;
  wire                    glb_off;
  wire [NUM_PORTS-1:0]    port_on;
  wire [NUM_PORTS-1:0]    port_off;

  // Time base and overcurrent inputs
  reg [31:0]              pre_q;
  reg                     tick_q;
  reg [NUM_PORTS-1:0]     oc_meta_q;
  reg [NUM_PORTS-1:0]     oc_sync_q;
  reg                     oc_glb_q;
  reg [NUM_PORTS-1:0]     oc_port_q;

  // Status views for readback
  reg [31:0]              desc_view;
  reg [31:0]              mask_view;
  reg [31:0]              pwr_view;

  integer                 k;

  // Zero wait states; every transfer answers OKAY
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = rdata_q;

  // Address phase is taken on a selected NONSEQ or SEQ with the bus ready
  assign take = hsel & hready & htrans[1];

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q   <= 1'b0;
      addr_q <= {`RHDA_ADDR_W{1'b0}};
    end else begin
      wr_q   <= take & hwrite;
      if (take)
        addr_q <= haddr[`RHDA_ADDR_W-1:0];
    end
  end

  // Writes land in the data phase, one strobe per register
  assign wr_desc = wr_q & (addr_q == `RHDA_DESC_A_ADDR);
  assign wr_mask = wr_q & (addr_q == `RHDA_MASK_ADDR);
  assign wr_pwr  = wr_q & (addr_q == `RHDA_PWR_ADDR);

  // Descriptor next values; reserved, compound and count bits are not stored
  always @* begin
    pgd_d  = pgd_q;
    no_overcurrent_guard_d = no_overcurrent_guard_q;
    overcurrent_report_mode_d = overcurrent_report_mode_q;
    nps_d  = nps_q;
    psm_d  = psm_q;
    if (wr_desc) begin
      pgd_d  = hwdata[`RHDA_PGD_MSB:`RHDA_PGD_LSB];
      no_overcurrent_guard_d = hwdata[`RHDA_NO_OVERCURRENT_GUARD_BIT];
      overcurrent_report_mode_d = hwdata[`RHDA_OVERCURRENT_REPORT_MODE_BIT];
      nps_d  = hwdata[`RHDA_NPS_BIT];
      psm_d  = hwdata[`RHDA_PSM_BIT];
    end
  end

  // Mask next value; bit 0 of the word has no port behind it
  always @* begin
    mask_d = mask_q;
    if (wr_mask)
      mask_d = hwdata[NUM_PORTS:1];
  end

  // Descriptor and mask storage
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pgd_q  <= `RHDA_PGD_RST;
      no_overcurrent_guard_q <= `RHDA_NO_OVERCURRENT_GUARD_RST;
      overcurrent_report_mode_q <= `RHDA_PSM_RST;
      nps_q  <= `RHDA_NPS_RST;
      psm_q  <= `RHDA_PSM_RST;
      mask_q <= {NUM_PORTS{1'b0}};
    end else begin
      pgd_q  <= pgd_d;
      no_overcurrent_guard_q <= no_overcurrent_guard_d;
      overcurrent_report_mode_q <= overcurrent_report_mode_d;
      nps_q  <= nps_d;
      psm_q  <= psm_d;
      mask_q <= mask_d;
    end
  end

  // Power commands are one-cycle strobes decoded straight from write data
  assign glb_on   = wr_pwr & hwdata[`RHDA_GLB_ON_BIT];
  assign glb_off  = wr_pwr & hwdata[`RHDA_GLB_OFF_BIT];
  assign port_on  = {NUM_PORTS{wr_pwr}} & hwdata[`RHDA_PORT_ON_LSB+NUM_PORTS:`RHDA_PORT_ON_LSB+1];
  assign port_off = {NUM_PORTS{wr_pwr}} &
                    hwdata[`RHDA_PORT_OFF_LSB+NUM_PORTS:`RHDA_PORT_OFF_LSB+1];

  // Free running 2 ms tick; tick phase is arbitrary, so timers add one unit
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pre_q  <= 32'h00000000;
      tick_q <= 1'b0;
    end else if (pre_q >= TICK_CYCLES - 1) begin
      pre_q  <= 32'h00000000;
      tick_q <= 1'b1;
    end else begin
      pre_q  <= pre_q + 32'h00000001;
      tick_q <= 1'b0;
    end
  end

  // One switch and timer per port
  genvar p;
  generate
    for (p = 0; p < NUM_PORTS; p = p + 1) begin : g_port
      rhda_port u_port (
        .hclk               (hclk),
        .hresetn            (hresetn),
        .always_powered     (nps_q),
        .power_switch_style (psm_q),
        .port_power_mask    (mask_q[p]),
        .glb_on             (glb_on),
        .glb_off            (glb_off),
        .port_on            (port_on[p]),
        .port_off           (port_off[p]),
        .tick               (tick_q),
        .power_good_delay   (pgd_q),
        .port_power         (port_power[p]),
        .port_good          (port_good[p])
      );
    end
  endgenerate

  // Overcurrent pins come from off-chip and are synchronised first
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      oc_meta_q <= {NUM_PORTS{1'b0}};
      oc_sync_q <= {NUM_PORTS{1'b0}};
    end else begin
      oc_meta_q <= port_overcurrent;
      oc_sync_q <= oc_meta_q;
    end
  end

  // Report collectively or per port; nothing is reported without protection
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      oc_glb_q  <= 1'b0;
      oc_port_q <= {NUM_PORTS{1'b0}};
    end else if (no_overcurrent_guard_q) begin
      oc_glb_q  <= 1'b0;
      oc_port_q <= {NUM_PORTS{1'b0}};
    end else if (overcurrent_report_mode_q) begin
      oc_glb_q  <= 1'b0;
      oc_port_q <= oc_sync_q;
    end else begin
      oc_glb_q  <= |oc_sync_q;
      oc_port_q <= {NUM_PORTS{1'b0}};
    end
  end

  assign overcurrent_global = oc_glb_q;
  assign overcurrent_port   = oc_port_q;

  // Read views built from next values so a write followed by a read returns new data
  always @* begin
    desc_view = 32'h00000000;
    desc_view[`RHDA_PGD_MSB:`RHDA_PGD_LSB] = pgd_d;
    desc_view[`RHDA_NO_OVERCURRENT_GUARD_BIT] = no_overcurrent_guard_d;
    desc_view[`RHDA_OVERCURRENT_REPORT_MODE_BIT] = overcurrent_report_mode_d;
    desc_view[`RHDA_DT_BIT]   = `RHDA_DT_VAL;
    desc_view[`RHDA_NPS_BIT]  = nps_d;
    desc_view[`RHDA_PSM_BIT]  = psm_d;
    desc_view[`RHDA_NDP_MSB:`RHDA_NDP_LSB] = NDP_VAL;
  end

  // Port state views; power lags a command by one cycle, as the port registers it
  always @* begin
    mask_view = 32'h00000000;
    pwr_view  = 32'h00000000;
    for (k = 0; k < NUM_PORTS; k = k + 1) begin
      mask_view[k+1] = mask_d[k];
      pwr_view[k+1]  = port_power[k];
      pwr_view[`RHDA_GOOD_LSB+k+1] = port_good[k];
    end
  end

  // Read mux; unmapped offsets read zero
  always @* begin
    rdata_d = rdata_q;
    if (take && !hwrite) begin
      case (haddr[`RHDA_ADDR_W-1:0])
        `RHDA_DESC_A_ADDR: rdata_d = desc_view;
        `RHDA_MASK_ADDR:   rdata_d = mask_view;
        `RHDA_PWR_ADDR:    rdata_d = pwr_view;
        default:           rdata_d = 32'h00000000;
      endcase
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      rdata_q <= 32'h00000000;
    else
      rdata_q <= rdata_d;
  end

  // Field outputs straight from the stored bits; compound flag and port count are constants
  assign power_good_delay        = pgd_q;
  assign no_overcurrent_guard    = no_overcurrent_guard_q;
  assign overcurrent_report_mode = overcurrent_report_mode_q;
  assign compound_flag           = `RHDA_DT_VAL;
  assign always_powered          = nps_q;
  assign power_switch_style      = psm_q;
  assign downstream_port_count   = NDP_VAL;
  assign port_power_mask         = mask_q;

endmodule // rhda_top

//--- verification/rhda_checker.sv
// Concurrent checks on the root hub descriptor block ports
`timescale 1ns/1ps
`include "rhda_regs.vh"

module rhda_checker #(
  parameter NUM_PORTS = 2
) (
  input logic                 hclk,
  input logic                 hresetn,
  input logic                 hsel,
  input logic [31:0]          haddr,
  input logic [1:0]           htrans,
  input logic                 hwrite,
  input logic [31:0]          hwdata,
  input logic                 hready,
  input logic [31:0]          hrdata,
  input logic [NUM_PORTS-1:0] port_overcurrent,
  input logic [7:0]           power_good_delay,
  input logic                 no_overcurrent_guard,
  input logic                 overcurrent_report_mode,
  input logic                 compound_flag,
  input logic                 always_powered,
  input logic                 power_switch_style,
  input logic [7:0]           downstream_port_count,
  input logic [NUM_PORTS-1:0] port_power,
  input logic                 overcurrent_global,
  input logic [NUM_PORTS-1:0] overcurrent_port
);
  // Address phase of a descriptor access
  wire desc_acc = hsel && hready && htrans[1] && haddr[7:0] == `RHDA_DESC_A_ADDR;

  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  AST_RST_PGD: assert property ($rose(hresetn) |-> power_good_delay == `RHDA_PGD_RST)
    else $error("delay field wrong after reset");
  AST_RST_BITS: assert property ($rose(hresetn) |->
    {no_overcurrent_guard, always_powered, power_switch_style} == 3'b001)
    else $error("mode bits wrong after reset");
  AST_RST_MODE: assert property ($rose(hresetn) |->
    overcurrent_report_mode == power_switch_style)
    else $error("report mode differs from switch style after reset");
  AST_DT: assert property (compound_flag == 1'b0)
    else $error("compound flag set");
  AST_NDP: assert property (downstream_port_count == 8'(NUM_PORTS))
    else $error("port count wrong");
  AST_WR: assert property (desc_acc && hwrite ##1 hready |=>
    {power_good_delay, no_overcurrent_guard, overcurrent_report_mode, always_powered,
     power_switch_style} == {$past(hwdata[31:24]), $past(hwdata[12:11]), $past(hwdata[9:8])})
    else $error("descriptor write not applied");
  AST_RD: assert property (desc_acc && !hwrite |=>
    hrdata == {power_good_delay, 11'h000, no_overcurrent_guard, overcurrent_report_mode, 1'b0,
               always_powered, power_switch_style, downstream_port_count})
    else $error("descriptor read data wrong");
  AST_NPS: assert property (always_powered |-> &port_power)
    else $error("port unpowered while always powered");
  AST_NO_OVERCURRENT_GUARD: assert property (no_overcurrent_guard [*4] |->
    overcurrent_global == 1'b0 && overcurrent_port == '0)
    else $error("fault reported without protection");
  AST_OC_GLB: assert property (
    (!no_overcurrent_guard && !overcurrent_report_mode && $stable(port_overcurrent)) [*4]
    |-> overcurrent_global == |port_overcurrent)
    else $error("collective fault report wrong");
  AST_OC_PORT: assert property (
    (!no_overcurrent_guard && overcurrent_report_mode && $stable(port_overcurrent)) [*4]
    |-> overcurrent_port == port_overcurrent)
    else $error("per port fault report wrong");
endmodule // rhda_checker

bind rhda_top rhda_checker #(.NUM_PORTS(NUM_PORTS)) chk (.*);

//--- verification/tb.sv
// Self-checking testbench for the root hub descriptor block
`timescale 1ns/1ps
`include "rhda_regs.vh"

module tb;
  localparam int NP = 2;
  localparam int TK = 10;
  localparam logic [7:0] A = `RHDA_DESC_A_ADDR;
  localparam logic [7:0] M = `RHDA_MASK_ADDR;
  localparam logic [7:0] P = `RHDA_PWR_ADDR;
  logic          hclk = 1'b0;
  logic          hresetn = 1'b0;
  logic          hsel = 1'b0;
  logic [31:0]   haddr = 32'h0;
  logic [1:0]    htrans = 2'h0;
  logic          hwrite = 1'b0;
  logic [31:0]   hwdata = 32'h0;
  logic [NP-1:0] port_overcurrent = '0;
  wire  [31:0]   hrdata;
  wire           hreadyout;
  wire  [NP-1:0] ppm;
  wire  [NP-1:0] good;
  logic [31:0]   exp_q[$];
  logic          rd_pend = 1'b0;
  integer        seed = 5862;
  int            err_count = 0;
  int            samples_checked = 0;
  int            cycles = 0;

  rhda_top #(.NUM_PORTS(NP), .TICK_CYCLES(TK)) uut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(), .port_overcurrent(port_overcurrent),
    .power_good_delay(), .no_overcurrent_guard(), .overcurrent_report_mode(),
    .compound_flag(), .always_powered(), .power_switch_style(), .downstream_port_count(),
    .port_power_mask(ppm), .port_power(), .port_good(good), .overcurrent_global(),
    .overcurrent_port());

  // Clock at 100 MHz
  always #5 hclk = ~hclk;

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // One single transfer; waits on hready, never on a fixed count
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    xfer(1'b0, a, 32'h0);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge hclk);
  endtask

  // Read data is taken at the edge that ends the data phase
  always @(posedge hclk) begin
    if (rd_pend && hreadyout === 1'b1 && exp_q.size() > 0)
      check("hrdata", hrdata, exp_q.pop_front());
    if (hreadyout === 1'b1)
      rd_pend = hresetn && hsel && htrans[1] && !hwrite;
  end

  // A hang counts as a mismatch
  always @(posedge hclk) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      print_verdict();
    end
  end

  // Main sequence
  initial begin
    logic [31:0] d;
    cyc(6);
    hresetn <= 1'b1;
    rd(A, 32'hFF00_0902);
    rd(P, 32'h0);
    rd(8'h4C, 32'h0);
    wr(A, 32'hFFFF_FFFF);
    rd(A, 32'hFF00_1B02);
    // Reserved bits stay zero; count and compound bits get random junk
    for (int i = 0; i < 8; i++) begin
      d = $random(seed) & 32'hFF00_1FFF;
      wr(A, d);
      rd(A, (d & 32'hFF00_1B00) | 32'h2);
    end
    // Ganged switching ignores port commands
    wr(A, 32'h0200_0000);
    wr(P, 32'h6);
    rd(P, 32'h0);
    wr(P, 32'h1);
    rd(P, 32'h6);
    cyc(4 * TK);
    rd(P, 32'h0006_0006);
    wr(P, 32'h0001_0000);
    rd(P, 32'h0);
    // Individual switching, port 1 masked
    wr(A, 32'h0200_0100);
    wr(M, 32'h2);
    rd(M, 32'h2);
    check("port_power_mask", {30'h0, ppm}, 32'h1);
    wr(P, 32'h1);
    rd(P, 32'h4);
    wr(P, 32'h6);
    rd(P, 32'h6);
    wr(P, 32'h0001_0000);
    rd(P, 32'h2);
    wr(P, 32'h0002_0000);
    rd(P, 32'h0);
    // Always powered, zero delay
    wr(A, 32'h0000_0200);
    cyc(4 * TK);
    rd(P, 32'h0006_0006);
    check("port_good", {30'h0, good}, 32'h3);
    // Fault reporting in each mode with random pins
    for (int m = 0; m < 3; m++) begin
      wr(A, m == 0 ? 32'h1000 : (m == 1 ? 32'h0 : 32'h0800));
      repeat (6) begin
        port_overcurrent <= NP'($random(seed));
        cyc(6);
      end
    end
    port_overcurrent <= '0;
    // Reset in mid run restores the descriptor
    wr(A, 32'h1200_0300);
    hresetn <= 1'b0;
    cyc(3);
    hresetn <= 1'b1;
    rd(A, 32'hFF00_0902);
    cyc(2);
    print_verdict();
  end
endmodule // tb
